//--- hdl/secp_pkg.sv
// Shared constants and types of the serial EEPROM command and protection block
package secp_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  localparam logic [7:0] OP_ID_RD = 8'h83;
  localparam logic [7:0] OP_ID_WR = 8'h82;
  localparam logic [7:0] OP_NONE = 8'h00;

  // ****************************************************************
  // Address fields and protected regions
  // ****************************************************************
  localparam int ARR_AW = 10;
  localparam int ID_AW = 5;
  localparam int LOCK_SEL_BIT = 10;
  localparam logic [15:0] LOCK_ADDR = 16'h0400;
  localparam logic [9:0] QUARTER_BASE = 10'h300;
  localparam logic [9:0] HALF_BASE = 10'h200;
  localparam logic [1:0] PSIZE_NONE = 2'b00;
  localparam logic [1:0] PSIZE_QUARTER = 2'b01;
  localparam logic [1:0] PSIZE_HALF = 2'b10;

  // ****************************************************************
  // Start values of non-volatile bits (delivery state); reset does not load them
  // ****************************************************************
  localparam logic [1:0] PSIZE_RST = 2'b00;
  localparam logic LOCK_RST = 1'b0;
  localparam logic IDLK_RST = 1'b0;

  // ****************************************************************
  // Byte counts (opcode, address and first data byte)
  // ****************************************************************
  localparam logic [2:0] BYTES_OPC = 3'd1;
  localparam logic [2:0] BYTES_STWR = 3'd2;
  localparam logic [2:0] BYTES_ADDR = 3'd3;
  localparam logic [2:0] BYTES_MWR = 3'd4;

  // ****************************************************************
  // Synchroniser lane positions
  // ****************************************************************
  localparam int PIN_CS = 3;
  localparam int PIN_SCK = 2;
  localparam int PIN_MOSI = 1;
  localparam int PIN_PROT = 0;

  // Status byte, msb first
  typedef struct packed {
    logic lock;
    logic [2:0] zero;
    logic [1:0] psize;
    logic latch;
    logic busy;
  } secp_status_t;

  // Request towards the array datapath and its write timer
  typedef struct packed {
    logic commit;
    logic id_page;
    logic freeze;
    logic wstb;
    logic rstb;
    logic [7:0] wdata;
    logic [9:0] addr;
  } secp_req_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_OPC = 6'b000010,
    S_ADDR = 6'b000100,
    S_WDAT = 6'b001000,
    S_SEND = 6'b010000,
    S_WAIT = 6'b100000
  } secp_state_t;

endpackage : secp_pkg

//--- hdl/secp_top.sv
// Command decoder and write protection of the serial EEPROM slave
`timescale 1ns/10ps
`default_nettype none
module secp_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic PROT_N,
  input wire logic [7:0] ARRAY_RDATA,
  input wire logic ARRAY_DONE,
  output logic MISO_O,
  output logic MISO_OE,
  output secp_pkg::secp_status_t STATUS,
  output logic ID_LOCKED,
  output secp_pkg::secp_req_t REQ
);
  import secp_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pins;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic cs_n, mosi, sck_rise, sck_fall, cs_rise, cs_fall, hard;

  assign pins = {CS_N, SCK, MOSI, PROT_N};

  // Third stage only feeds edge detection; the first stage feeds nothing else
  always_ff @(posedge CLOCK) begin
    if (CE) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges seen at the system clock; the link clock is sampled, not used
  assign cs_n = s2_q[PIN_CS];
  assign mosi = s2_q[PIN_MOSI];
  assign sck_rise = s2_q[PIN_SCK] & ~s3_q[PIN_SCK];
  assign sck_fall = ~s2_q[PIN_SCK] & s3_q[PIN_SCK];
  assign cs_rise = s2_q[PIN_CS] & ~s3_q[PIN_CS];
  assign cs_fall = ~s2_q[PIN_CS] & s3_q[PIN_CS];

  // ****************************************************************
  // Command state
  // ****************************************************************
  secp_state_t st_q, st_d;
  logic armed_q, armed_d;
  logic [2:0] bit_q, bit_d, byte_q, byte_d;
  logic [7:0] sh_q, sh_d, op_q, op_d, tx_q, tx_d, sw_q, sw_d;
  logic [15:0] addr_q, addr_d;
  logic miso_q, miso_d, oe_q, oe_d;
  logic latch_q, latch_d, busy_q, busy_d;
  logic pst_q, pst_d, pfz_q, pfz_d, blk_q, blk_d;
  // Non-volatile bits survive reset; start values model the delivery state
  logic [1:0] psize_q = PSIZE_RST;
  logic lock_q = LOCK_RST;
  logic idlk_q = IDLK_RST;
  logic [1:0] psize_d;
  logic lock_d, idlk_d;
  secp_req_t req_q, req_d;
  logic [7:0] nb, src;
  logic [9:0] pa;
  logic done, frame_ok, prot_hit, is_id, lk_sel, id_ok;

  // Protected region test on the address that the last address byte completes;
  // later data bytes move the address, so the verdict is kept in blk_q
  always_comb begin
    unique case (psize_q)
      PSIZE_NONE: prot_hit = 1'b0;
      PSIZE_QUARTER: prot_hit = pa >= QUARTER_BASE;
      PSIZE_HALF: prot_hit = pa >= HALF_BASE;
      default: prot_hit = 1'b1;
    endcase
  end

  assign nb = {sh_q[6:0], mosi};
  assign is_id = (op_q == OP_ID_RD) || (op_q == OP_ID_WR);
  assign lk_sel = addr_q[LOCK_SEL_BIT];
  // Page address must leave upper bits zero; lock uses one fixed value
  assign id_ok = lk_sel ? (addr_q == LOCK_ADDR) : (addr_q[15:ID_AW] == '0);
  // Whole bytes only: select rose before a new bit started
  assign frame_ok = (bit_q == 3'd0);
  assign done = busy_q & ARRAY_DONE;
  assign hard = lock_q & ~s2_q[PIN_PROT];
  assign pa = {addr_q[1:0], nb};

  // Byte to send at the next byte boundary
  always_comb begin
    if (op_q == OP_STAT_RD) begin
      src = {lock_q, 3'b000, psize_q, latch_q, busy_q};
    end else if (is_id && lk_sel) begin
      src = {7'h00, idlk_q};
    end else begin
      src = ARRAY_RDATA;
    end
  end

  // Next state of the whole command engine
  always_comb begin
    st_d = st_q;
    armed_d = armed_q | cs_n;
    bit_d = bit_q;
    byte_d = byte_q;
    sh_d = sh_q;
    op_d = op_q;
    tx_d = tx_q;
    sw_d = sw_q;
    addr_d = addr_q;
    miso_d = miso_q;
    oe_d = oe_q;
    latch_d = latch_q;
    busy_d = busy_q;
    pst_d = pst_q;
    pfz_d = pfz_q;
    blk_d = blk_q;
    psize_d = psize_q;
    lock_d = lock_q;
    idlk_d = idlk_q;
    req_d = req_q;
    req_d.commit = 1'b0;
    req_d.wstb = 1'b0;
    req_d.rstb = 1'b0;
    // Write cycle end: apply pending bits, drop busy and latch
    if (done) begin
      busy_d = 1'b0;
      latch_d = 1'b0;
      pst_d = 1'b0;
      pfz_d = 1'b0;
      if (pst_q) begin
        lock_d = sw_q[7];
        psize_d = sw_q[3:2];
      end
      if (pfz_q) begin
        idlk_d = 1'b1;
      end
    end
    if (st_q == S_IDLE) begin
      if (cs_fall && armed_q) begin
        st_d = S_OPC;
        bit_d = 3'd0;
        byte_d = 3'd0;
        op_d = OP_NONE;
        addr_d = '0;
        blk_d = 1'b0;
      end
    end else if (cs_rise) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
      if (frame_ok) begin
        unique case (op_q)
          OP_SET_LATCH: if (byte_q == BYTES_OPC) latch_d = 1'b1;
          OP_CLR_LATCH: if (byte_q == BYTES_OPC) latch_d = 1'b0;
          OP_STAT_WR: begin
            if (byte_q >= BYTES_STWR && latch_q && !busy_q && !hard) begin
              busy_d = 1'b1;
              pst_d = 1'b1;
              req_d.commit = 1'b1;
            end
          end
          OP_ARR_WR: begin
            if (byte_q >= BYTES_MWR && latch_q && !busy_q && !blk_q) begin
              busy_d = 1'b1;
              req_d.commit = 1'b1;
            end
          end
          OP_ID_WR: begin
            if (byte_q >= BYTES_MWR && latch_q && !busy_q && !idlk_q && id_ok) begin
              busy_d = 1'b1;
              pfz_d = lk_sel;
              req_d.commit = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end else begin
      // Falling clock: move the next read bit onto the line
      if (sck_fall && st_q == S_SEND) begin
        oe_d = 1'b1;
        if (bit_q == 3'd0) begin
          miso_d = src[7];
          tx_d = {src[6:0], 1'b0};
        end else begin
          miso_d = tx_q[7];
          tx_d = {tx_q[6:0], 1'b0};
        end
      end
      // Rising clock: count bits even when waiting, so framing stays exact
      if (sck_rise) begin
        sh_d = nb;
        bit_d = bit_q + 3'd1;
        if (bit_q == 3'd7 && byte_q != 3'd7) begin
          byte_d = byte_q + 3'd1;
        end
        if (bit_q == 3'd7) begin
          unique case (st_q)
            S_OPC: begin
              op_d = nb;
              unique case (nb)
                OP_SET_LATCH, OP_CLR_LATCH: st_d = S_WAIT;
                OP_STAT_RD: st_d = S_SEND;
                OP_STAT_WR: st_d = S_WDAT;
                OP_ARR_RD: st_d = busy_q ? S_WAIT : S_ADDR;
                OP_ARR_WR, OP_ID_RD, OP_ID_WR: st_d = S_ADDR;
                default: begin
                  st_d = S_WAIT;
                  op_d = OP_NONE;
                end
              endcase
            end
            S_ADDR: begin
              addr_d = {addr_q[7:0], nb};
              if (byte_q == BYTES_ADDR - 3'd1) begin
                blk_d = prot_hit;
                if (op_q == OP_ARR_WR || op_q == OP_ID_WR) begin
                  st_d = S_WDAT;
                end else begin
                  st_d = S_SEND;
                  req_d.rstb = 1'b1;
                  req_d.id_page = is_id;
                  req_d.addr = {addr_q[1:0], nb};
                end
              end
            end
            S_WDAT: begin
              if (op_q == OP_STAT_WR) begin
                if (byte_q == BYTES_OPC) sw_d = nb;
              end else if (!(is_id && lk_sel)) begin
                req_d.wstb = 1'b1;
                req_d.wdata = nb;
                req_d.id_page = is_id;
                req_d.addr = addr_q[ARR_AW-1:0];
                if (is_id) begin
                  addr_d[ID_AW-1:0] = addr_q[ID_AW-1:0] + 5'd1;
                end else begin
                  addr_d[ARR_AW-1:0] = addr_q[ARR_AW-1:0] + 10'd1;
                end
              end
            end
            S_SEND: begin
              // Status read repeats its byte; array reads advance and wrap
              if (op_q != OP_STAT_RD && !(is_id && lk_sel)) begin
                req_d.rstb = 1'b1;
                if (is_id) begin
                  addr_d[ID_AW-1:0] = addr_q[ID_AW-1:0] + 5'd1;
                  req_d.addr = {5'd0, addr_q[ID_AW-1:0] + 5'd1};
                end else begin
                  addr_d[ARR_AW-1:0] = addr_q[ARR_AW-1:0] + 10'd1;
                  req_d.addr = addr_q[ARR_AW-1:0] + 10'd1;
                end
              end
            end
            default: ; // Waiting: input ignored
          endcase
        end
      end
    end
  end

  // Volatile state; reset deselects and clears latch and busy
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q <= S_IDLE;
      armed_q <= 1'b0;
      bit_q <= 3'd0;
      byte_q <= 3'd0;
      sh_q <= 8'h00;
      op_q <= OP_NONE;
      tx_q <= 8'h00;
      sw_q <= 8'h00;
      addr_q <= 16'h0000;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      pst_q <= 1'b0;
      pfz_q <= 1'b0;
      blk_q <= 1'b0;
      req_q <= '0;
    end else if (CE) begin
      st_q <= st_d;
      armed_q <= armed_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      sh_q <= sh_d;
      op_q <= op_d;
      tx_q <= tx_d;
      sw_q <= sw_d;
      addr_q <= addr_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
      latch_q <= latch_d;
      busy_q <= busy_d;
      pst_q <= pst_d;
      pfz_q <= pfz_d;
      blk_q <= blk_d;
      req_q <= req_d;
    end
  end

  // Non-volatile bits have no reset branch; only the command engine moves them
  always_ff @(posedge CLOCK) begin
    if (CE) begin
      psize_q <= psize_d;
      lock_q <= lock_d;
      idlk_q <= idlk_d;
    end
  end

  assign MISO_O = miso_q;
  assign MISO_OE = oe_q;
  assign STATUS = {lock_q, 3'b000, psize_q, latch_q, busy_q};
  assign ID_LOCKED = idlk_q;
  assign REQ = req_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_cycle_end;
    busy_q && ARRAY_DONE && CE && !cs_rise;
  endsequence
  sequence seq_idle_after;
    !busy_q && !latch_q;
  endsequence

  latch_set_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && st_q == S_WAIT && cs_rise && op_q == OP_SET_LATCH && frame_ok
      && byte_q == BYTES_OPC |=> latch_q)
    else $error("latch not set by set command");
  latch_clr_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && st_q == S_WAIT && cs_rise && op_q == OP_CLR_LATCH && frame_ok
      && byte_q == BYTES_OPC && !done |=> !latch_q)
    else $error("latch not cleared by clear command");
  frame_check_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(req_q.commit) |-> $past(bit_q) == 3'd0 && $past(cs_rise))
    else $error("write committed off a byte boundary");
  need_latch_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(req_q.commit) |-> $past(latch_q) && busy_q)
    else $error("write committed without latch");
  hard_guard_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(pst_q) |-> !$past(hard))
    else $error("status write taken under hard guard");
  region_guard_a: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(req_q.commit) && op_q == OP_ARR_WR |-> !$past(blk_q))
    else $error("write committed into protected region");
  cycle_end_a: assert property (@(posedge CLOCK) disable iff (RST)
    seq_cycle_end |=> seq_idle_after)
    else $error("latch or busy left set after write cycle");
  out_release_a: assert property (@(posedge CLOCK) disable iff (RST)
    CE && cs_n && $past(cs_n) && $past(CE) |=> !MISO_OE)
    else $error("output driven while deselected");
  wait_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
    st_q == S_WAIT |-> !oe_q ##1 (st_q == S_WAIT || st_q == S_IDLE))
    else $error("output active or input taken while waiting");

endmodule : secp_top
`default_nettype wire

//--- tb/secp_master.sv
// SPI bus master model driving the select, clock and data pins of the block
`timescale 1ns/10ps
`default_nettype none
module secp_master (
  input wire logic CLOCK,
  output logic CS_N,
  output logic SCK,
  output logic MOSI,
  input wire logic MISO
);
  // ****************************************************************
  // Idle pins
  // ****************************************************************
  initial begin
    CS_N = 1'b1;
    SCK = 1'b0; // Clock idles low and stands still between frames
    MOSI = 1'b0;
  end

  // Pins change one small delay after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : tick

  // One frame; cut drops bits off the end to break byte framing
  task automatic frame(input logic [7:0] b[$], input int cut, output logic [7:0] rx[$]);
    logic [7:0] r;
    int nb;
    r = 8'h00;
    rx = {};
    nb = 8 * b.size() - cut;
    CS_N = 1'b0;
    tick(4);
    // Data moves mid low phase so it never races the sampled rise
    for (int i = 0; i < nb; i++) begin
      tick(2);
      MOSI = b[i / 8][7 - i % 8];
      tick(3);
      SCK = 1'b1;
      r = {r[6:0], MISO};
      if (i % 8 == 7) begin
        rx.push_back(r);
      end
      tick(3);
      SCK = 1'b0;
    end
    MOSI = ~MOSI; // Released data line does not keep its last value
    CS_N = 1'b1;
    tick(8);
  endtask : frame
endmodule : secp_master
`default_nettype wire

//--- tb/test_secp_top.sv
// Self-checking testbench of the command decoder and write protection block
`timescale 1ns/10ps
`default_nettype none
module test_secp_top;
  import secp_pkg::*;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  logic PROT_N = 1'b1;
  logic ARRAY_DONE = 1'b0;
  logic [7:0] ARRAY_RDATA = 8'h00;
  logic CS_N, SCK, MOSI, MISO_O, MISO_OE, ID_LOCKED, miso, oe_seen;
  logic miso_last = 1'b0;
  secp_status_t STATUS;
  secp_req_t REQ;
  int err_total = 0;
  int check_count = 0;
  int commits = 0;
  int cyc = 0;
  int m_lat = 0;
  int m_busy = 0;
  int m_ps = 0;
  int m_lock = 0;
  logic [9:0] al[4] = '{10'h1FF, 10'h200, 10'h2FF, 10'h300};

  always #10 CLOCK = ~CLOCK;

  // Undriven output line toggles so a stale value never matches
  assign miso = MISO_OE ? MISO_O : ~miso_last;
  always @(posedge CLOCK) miso_last <= miso;

  secp_top DUT (.CLOCK(CLOCK), .RST(RST), .CE(CE), .CS_N(CS_N), .SCK(SCK), .MOSI(MOSI),
    .PROT_N(PROT_N), .ARRAY_RDATA(ARRAY_RDATA), .ARRAY_DONE(ARRAY_DONE), .MISO_O(MISO_O),
    .MISO_OE(MISO_OE), .STATUS(STATUS), .ID_LOCKED(ID_LOCKED), .REQ(REQ));
  secp_master M (.CLOCK(CLOCK), .CS_N(CS_N), .SCK(SCK), .MOSI(MOSI), .MISO(miso));

  // Commit counter, output-enable watch and hang limit
  always @(posedge CLOCK) begin
    cyc++;
    if (REQ.commit === 1'b1) commits++;
    if (MISO_OE === 1'b1) oe_seen = 1'b1;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] exp_st();
    return {m_lock[0], 3'b000, m_ps[1:0], m_lat[0], m_busy[0]};
  endfunction : exp_st

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Frame, commit check, busy poll during the write cycle, then status
  task automatic op(input logic [7:0] b[$], input int cut, input bit go, input bit sw);
    logic [7:0] rx[$];
    int c0;
    c0 = commits;
    M.frame(b, cut, rx);
    chk(8'(commits - c0), {7'd0, go}, "commit");
    if (go) begin
      m_busy = 1;
      oe_seen = 1'b0;
      M.frame('{OP_STAT_RD, 8'h00, 8'h00}, 0, rx);
      chk(rx[1], exp_st(), "polled status");
      chk(rx[2], exp_st(), "repeated status");
      chk({MISO_OE, 6'd0, oe_seen}, 8'h01, "output enable");
      ARRAY_DONE = 1'b1;
      M.tick(1);
      ARRAY_DONE = 1'b0;
      M.tick(3);
      m_busy = 0;
      m_lat = 0;
      if (sw) begin
        m_ps = b[1][3:2];
        m_lock = b[1][7];
      end
    end
    chk(STATUS, exp_st(), "status");
  endtask : op

  task automatic latch(input int v);
    m_lat = v;
    op('{v ? OP_SET_LATCH : OP_CLR_LATCH}, 0, 0, 0);
  endtask : latch

  task automatic sw(input logic [7:0] v);
    op('{OP_STAT_WR, v}, 0, m_lat != 0 && !(m_lock != 0 && PROT_N == 1'b0), 1);
  endtask : sw

  // Upper six address bits are random and must not matter
  task automatic aw(input logic [9:0] a, input int cut);
    bit pr = m_ps == 3 || (m_ps == 2 && a >= HALF_BASE) || (m_ps == 1 && a >= QUARTER_BASE);
    op('{OP_ARR_WR, {6'($urandom), a[9:8]}, a[7:0], 8'($urandom)}, cut,
      m_lat != 0 && !pr && cut == 0, 0);
  endtask : aw

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] rx[$];
    oe_seen = 1'b0;
    void'($urandom(32'hf627));
    ARRAY_RDATA = 8'($urandom);
    repeat (16) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    M.tick(8);
    chk(STATUS, exp_st(), "reset status");
    latch(1);
    latch(0);
    sw(8'h8C);
    $display("test latch and refusal done");
    // Every protect size against addresses either side of each boundary
    for (int p = 0; p < 4; p++) begin
      latch(1);
      sw({1'b0, 3'($urandom), p[1:0], 2'($urandom)});
      foreach (al[i]) begin
        latch(1);
        aw(al[i], 0);
      end
    end
    $display("test protect sizes done");
    latch(1);
    aw(10'h000, 3);
    latch(0);
    op('{OP_SET_LATCH, 8'h00}, 5, 0, 0);
    $display("test framing done");
    latch(1);
    sw(8'h80);
    PROT_N = 1'b0;
    latch(1);
    sw(8'h0C);
    PROT_N = 1'b1;
    sw(8'h00);
    $display("test hard guard done");
    latch(0);
    oe_seen = 1'b0;
    op('{8'hFF, OP_SET_LATCH}, 0, 0, 0);
    chk({7'd0, oe_seen}, 8'h00, "unknown opcode output");
    $display("test unknown opcode done");
    // Page write, page freeze, refused page write, lock status and array reads
    latch(1);
    op('{OP_ID_WR, 8'h00, 8'h01, 8'($urandom)}, 0, 1, 0);
    latch(1);
    op('{OP_ID_WR, 8'h04, 8'h00, 8'h00}, 0, 1, 0);
    chk({7'd0, ID_LOCKED}, 8'h01, "page frozen");
    latch(1);
    op('{OP_ID_WR, 8'h00, 8'h02, 8'h5A}, 0, 0, 0);
    M.frame('{OP_ID_RD, 8'h04, 8'h00, 8'h00}, 0, rx);
    chk(rx[3], 8'h01, "lock status");
    M.frame('{OP_ARR_RD, 8'($urandom), 8'($urandom), 8'h00, 8'h00}, 0, rx);
    chk(rx[3], ARRAY_RDATA, "array read");
    chk(rx[4], ARRAY_RDATA, "array read next");
    $display("test page and reads done");
    // Mid-run reset keeps the protect size; a frozen block ignores a frame
    latch(1);
    sw(8'h08);
    latch(1);
    RST = 1'b1;
    M.tick(3);
    RST = 1'b0;
    m_lat = 0;
    M.tick(4);
    chk(STATUS, exp_st(), "status after reset");
    CE = 1'b0;
    M.frame('{OP_SET_LATCH}, 0, rx);
    CE = 1'b1;
    M.tick(4);
    chk(STATUS, exp_st(), "frozen frame");
    $display("test reset and freeze done");
    print_verdict();
  end
endmodule : test_secp_top
`default_nettype wire
